/* design/dra_pkg.sv */
/*
  Shared constants for the display-memory addressing and re-map block:
  opcodes, re-map field positions, reset values and scroll timing.
  Assumes a 200 MHz core clock and a byte stream already split into
  command and data bytes by the host port front end.
*/
package dra_pkg;
  // opcodes
  localparam logic [7:0] OP_SCROLL_SETUP = 8'h26;
  localparam logic [7:0] OP_SCROLL_STOP = 8'h2e;
  localparam logic [7:0] OP_SCROLL_GO = 8'h2f;
  localparam logic [7:0] OP_COL_WIN = 8'h15;
  localparam logic [7:0] OP_ROW_WIN = 8'h75;
  localparam logic [7:0] OP_CONTRAST = 8'h81;
  localparam logic [7:0] OP_RANGE_QTR = 8'h84;
  localparam logic [7:0] OP_RANGE_HALF = 8'h85;
  localparam logic [7:0] OP_RANGE_FULL = 8'h87;
  localparam logic [7:0] OP_REMAP = 8'ha0;

  // re-map byte fields
  localparam int RM_COL = 0;
  localparam int RM_COM = 1;
  localparam int RM_BIT = 2;
  localparam int RM_VERT = 3;
  localparam int RM_MONO = 4;
  localparam logic [4:0] REMAP_RESET = 5'h00;

  // scroll parameter fields
  localparam int SC_DIR = 4;
  localparam int SC_STEPS = 5;

  // current range codes
  localparam logic [1:0] RANGE_QTR = 2'h0;
  localparam logic [1:0] RANGE_HALF = 2'h1;
  localparam logic [1:0] RANGE_FULL = 2'h2;
  localparam logic [7:0] CONTRAST_RESET = 8'h00;

  // scroll interval: base step 20 ms, codes double it
  localparam int CLK_MHZ = 200;
  localparam int SCROLL_BASE_MS = 20;
  localparam int SCROLL_BASE_CYC = SCROLL_BASE_MS * 1000 * CLK_MHZ;

  typedef enum logic [1:0] {DRA_RANGE_Q, DRA_RANGE_H, DRA_RANGE_F, DRA_RANGE_X} dra_unused_t;
endpackage : dra_pkg

/* design/dra_scroll_timer.sv */
/*
  Scroll tick generator: one pulse per column shift while enabled.
  Assumes the same clock and reset as the command block.
*/
module dra_scroll_timer
  import dra_pkg::*;
#(
  parameter int BASE_CYC = SCROLL_BASE_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic [1:0] interval,
  output logic tick
);
  logic [31:0] cnt_q;
  logic [31:0] limit;

  // interval code doubles the base period per step
  assign limit = (BASE_CYC << interval) - 1;
  assign tick = enable && (cnt_q >= limit);

  // counter restarts whenever scrolling is stopped
  always_ff @(posedge clock) begin
    if (rst || !enable || tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
endmodule : dra_scroll_timer

/* design/dra_core.sv */
/*
  Command interpreter and address generator for a 256x32 gray-scale
  display memory: scroll setup/stop/start, column and row windows with
  pointer advance, contrast, current range and the re-map byte.
  Assumes cmd_valid is a one-cycle strobe from the host port
  on this clock; mem_access pulses once per completed memory access.
*/
//////////////////////////////////////////////////////////////////////////
// How it works
// - opcode 26h then five scroll parameter bytes
// - seven-bit start column, five-bit start row
// - parameter five bit four picks direction
// - low bits pick shift interval
// - stop scrolls at once, no restore
// - start uses last loaded scroll setup
// - column window stores bounds, loads pointer
// - row window stores bounds, loads pointer
// - horizontal mode: column steps, wraps, row steps
// - vertical mode: row steps, wraps, column steps
// - row wraps to start after end row
// - eight-bit contrast level, linear current
// - quarter, half, full range; half at reset
// - gray mode column re-map reverses pairs
// - mono mode column re-map reverses order
// - common re-map flips scan direction
// - gray bit re-map swaps nibbles
// - mono bit re-map reverses bit order
// - re-map bit four selects mono mode
// - re-map byte clears to gray, horizontal
module dra_core
  import dra_pkg::*;
#(
  parameter int SCROLL_CYC = SCROLL_BASE_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_valid,
  input wire logic [7:0] data_in,
  input wire logic mem_access,
  output logic [6:0] col_ptr,
  output logic [4:0] row_ptr,
  output logic [7:0] data_mapped,
  output logic [6:0] seg_column,
  output logic [4:0] com_row,
  output logic [7:0] contrast_level,
  output logic [1:0] current_range,
  output logic col_remap,
  output logic com_remap,
  output logic bit_remap,
  output logic vert_incr,
  output logic mono_mode,
  output logic scroll_active,
  output logic scroll_dir_dec,
  output logic [6:0] scroll_col_start,
  output logic [6:0] scroll_col_end,
  output logic [4:0] scroll_row_start,
  output logic [4:0] scroll_row_end,
  output logic [1:0] scroll_interval,
  output logic scroll_tick
);
  //////////////////////////////////////////////////////////////////////////
  // parameter collection state
  typedef enum logic [2:0] {
    DRA_IDLE, DRA_SCROLL, DRA_COLWIN, DRA_ROWWIN, DRA_CONTRAST, DRA_REMAP
  } dra_state_t;

  dra_state_t state_q, state_d;
  logic [2:0] idx_q, idx_d;
  logic [7:0] sc_par_q [SC_STEPS - 1]; // fifth byte is used straight off the bus
  logic [6:0] col_start_q, col_end_q, col_q;
  logic [4:0] row_start_q, row_end_q, row_q;
  logic [7:0] contrast_q;
  logic [1:0] range_q;
  logic [4:0] remap_q;
  logic active_q;
  logic [6:0] sc_a_q, sc_c_q;
  logic [4:0] sc_b_q, sc_d_q;
  logic sc_dir_q;
  logic [1:0] sc_int_q;

  //////////////////////////////////////////////////////////////////////////
  // decode of the incoming byte
  logic is_idle, op_byte, par_byte, last_par;
  logic [2:0] par_count;
  assign is_idle = (state_q == DRA_IDLE);
  assign op_byte = cmd_valid && is_idle;
  assign par_byte = cmd_valid && !is_idle;
  assign par_count = (state_q == DRA_SCROLL) ? 3'(SC_STEPS) :
                     (state_q == DRA_COLWIN || state_q == DRA_ROWWIN) ? 3'h2 : 3'h1;
  assign last_par = par_byte && (idx_q == par_count - 3'h1);

  // next-state: opcode picks how many parameter bytes follow
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    if (op_byte) begin
      idx_d = 3'h0;
      unique case (cmd_byte)
        OP_SCROLL_SETUP: state_d = DRA_SCROLL;
        OP_COL_WIN: state_d = DRA_COLWIN;
        OP_ROW_WIN: state_d = DRA_ROWWIN;
        OP_CONTRAST: state_d = DRA_CONTRAST;
        OP_REMAP: state_d = DRA_REMAP;
        default: state_d = DRA_IDLE; // single-byte or unknown opcode
      endcase
    end else if (last_par) begin
      state_d = DRA_IDLE;
      idx_d = 3'h0;
    end else if (par_byte) begin
      idx_d = idx_q + 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= DRA_IDLE;
      idx_q <= 3'h0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // scroll setup bytes, held aside until the fifth arrives
  logic scroll_load;
  assign scroll_load = last_par && (state_q == DRA_SCROLL);

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < SC_STEPS - 1; i++) sc_par_q[i] <= 8'h00;
    end else if (par_byte && state_q == DRA_SCROLL && !last_par) begin
      sc_par_q[idx_q[1:0]] <= cmd_byte;
    end
  end

  // window is latched whole so a running scroll never sees half a setup
  always_ff @(posedge clock) begin
    if (rst) begin
      sc_a_q <= 7'h00;
      sc_b_q <= 5'h00;
      sc_c_q <= 7'h00;
      sc_d_q <= 5'h00;
      sc_dir_q <= 1'b0;
      sc_int_q <= 2'h0;
    end else if (scroll_load) begin
      sc_a_q <= sc_par_q[0][6:0];
      sc_b_q <= sc_par_q[1][4:0];
      sc_c_q <= sc_par_q[2][6:0];
      sc_d_q <= sc_par_q[3][4:0];
      sc_dir_q <= cmd_byte[SC_DIR];
      sc_int_q <= cmd_byte[1:0];
    end
  end

  // start and stop; stop leaves memory as scrolled
  always_ff @(posedge clock) begin
    if (rst) begin
      active_q <= 1'b0;
    end else if (op_byte && cmd_byte == OP_SCROLL_STOP) begin
      active_q <= 1'b0;
    end else if (op_byte && cmd_byte == OP_SCROLL_GO) begin
      active_q <= 1'b1;
    end
  end

  dra_scroll_timer #(
    .BASE_CYC(SCROLL_CYC)
  ) u_timer (
    .clock(clock),
    .rst(rst),
    .enable(active_q),
    .interval(sc_int_q),
    .tick(scroll_tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // contrast, range and re-map settings
  always_ff @(posedge clock) begin
    if (rst) begin
      contrast_q <= CONTRAST_RESET;
      range_q <= RANGE_HALF;
      remap_q <= REMAP_RESET;
    end else begin
      if (last_par && state_q == DRA_CONTRAST) contrast_q <= cmd_byte;
      if (last_par && state_q == DRA_REMAP) remap_q <= cmd_byte[4:0];
      if (op_byte && cmd_byte == OP_RANGE_QTR) range_q <= RANGE_QTR;
      if (op_byte && cmd_byte == OP_RANGE_HALF) range_q <= RANGE_HALF;
      if (op_byte && cmd_byte == OP_RANGE_FULL) range_q <= RANGE_FULL;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // window pointers
  logic win_col_start, win_col_end, win_row_start, win_row_end;
  logic col_at_end, row_at_end;
  logic vert;
  assign vert = remap_q[RM_VERT];
  assign win_col_start = par_byte && state_q == DRA_COLWIN && idx_q == 3'h0;
  assign win_col_end = last_par && state_q == DRA_COLWIN;
  assign win_row_start = par_byte && state_q == DRA_ROWWIN && idx_q == 3'h0;
  assign win_row_end = last_par && state_q == DRA_ROWWIN;
  assign col_at_end = (col_q == col_end_q);
  assign row_at_end = (row_q == row_end_q);

  // a window byte beats an access in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      col_start_q <= 7'h00;
      col_end_q <= 7'h7f;
      col_q <= 7'h00;
    end else if (win_col_start) begin
      col_start_q <= cmd_byte[6:0];
      col_q <= cmd_byte[6:0];
    end else if (win_col_end) begin
      col_end_q <= cmd_byte[6:0];
      col_q <= col_start_q;
    end else if (mem_access && !cmd_valid) begin
      if (!vert) begin
        col_q <= col_at_end ? col_start_q : col_q + 7'h1;
      end else if (row_at_end) begin
        col_q <= col_at_end ? col_start_q : col_q + 7'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      row_start_q <= 5'h00;
      row_end_q <= 5'h1f;
      row_q <= 5'h00;
    end else if (win_row_start) begin
      row_start_q <= cmd_byte[4:0];
      row_q <= cmd_byte[4:0];
    end else if (win_row_end) begin
      row_end_q <= cmd_byte[4:0];
      row_q <= row_start_q;
    end else if (mem_access && !cmd_valid) begin
      if (vert) begin
        row_q <= row_at_end ? row_start_q : row_q + 5'h1;
      end else if (col_at_end) begin
        row_q <= row_at_end ? row_start_q : row_q + 5'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // data and address mapping toward the display memory
  logic [7:0] swapped, reversed;
  logic [6:0] col_max;
  assign swapped = {data_in[3:0], data_in[7:4]};
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_rev
      assign reversed[g] = data_in[7 - g];
    end
  endgenerate

  // mono packs 8 pixels per byte, so only 32 columns span the row
  assign col_max = remap_q[RM_MONO] ? 7'h1f : 7'h7f;

  logic [7:0] data_sel;
  assign data_sel = !remap_q[RM_BIT] ? data_in :
                    (remap_q[RM_MONO] ? reversed : swapped);

  always_ff @(posedge clock) begin
    if (rst) begin
      data_mapped <= 8'h00;
      seg_column <= 7'h00;
      com_row <= 5'h00;
    end else begin
      data_mapped <= data_sel;
      // column re-map reverses pair/group order
      seg_column <= remap_q[RM_COL] ? 7'(col_max - (col_q & col_max)) : (col_q & col_max);
      com_row <= remap_q[RM_COM] ? 5'(5'h1f - row_q) : row_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs straight from registers
  assign col_ptr = col_q;
  assign row_ptr = row_q;
  assign contrast_level = contrast_q;
  assign current_range = range_q;
  assign col_remap = remap_q[RM_COL];
  assign com_remap = remap_q[RM_COM];
  assign bit_remap = remap_q[RM_BIT];
  assign vert_incr = remap_q[RM_VERT];
  assign mono_mode = remap_q[RM_MONO];
  assign scroll_active = active_q;
  assign scroll_dir_dec = sc_dir_q;
  assign scroll_col_start = sc_a_q;
  assign scroll_col_end = sc_c_q;
  assign scroll_row_start = sc_b_q;
  assign scroll_row_end = sc_d_q;
  assign scroll_interval = sc_int_q;
endmodule : dra_core

/* tb/dra_monitor.sv */
/*
  Port checker for dra_core, bound into every instance of it.
  Assumes one clock domain and a synchronous active-high rst.
*/
module dra_monitor
  import dra_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_valid,
  input wire logic [7:0] data_in,
  input wire logic mem_access,
  input wire logic [6:0] col_ptr,
  input wire logic [4:0] row_ptr,
  input wire logic [7:0] data_mapped,
  input wire logic [7:0] contrast_level,
  input wire logic [1:0] current_range,
  input wire logic col_remap,
  input wire logic com_remap,
  input wire logic bit_remap,
  input wire logic vert_incr,
  input wire logic mono_mode,
  input wire logic scroll_active,
  input wire logic scroll_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // expected byte after re-map; step is an access not swallowed by a command
  wire logic [7:0] rev_in = {<<{data_in}};
  wire logic [7:0] exp_map = !bit_remap ? data_in : mono_mode ? rev_in : {data_in[3:0], data_in[7:4]};
  wire logic step = mem_access && !cmd_valid;
  wire logic [6:0] mode_bits = {current_range, col_remap, com_remap, bit_remap, vert_incr, mono_mode};
  ////////////////////////////////////////
  data_map_a: assert property (!$past(rst) |-> data_mapped == $past(exp_map))
    else $error("re-mapped byte wrong");
  ptr_hold_a: assert property (!mem_access && !cmd_valid |=> $stable(col_ptr) && $stable(row_ptr))
    else $error("pointer moved without access");
  horiz_step_a: assert property (step && !vert_incr |=> !$stable(row_ptr) || col_ptr == $past(col_ptr) + 7'h1)
    else $error("column step wrong");
  vert_step_a: assert property (step && vert_incr |=> !$stable(col_ptr) || row_ptr == $past(row_ptr) + 5'h1)
    else $error("row step wrong");
  contrast_cause_a: assert property (!$past(rst) && !$stable(contrast_level) |-> $past(cmd_valid))
    else $error("contrast changed without command");
  mode_cause_a: assert property (!$past(rst) && !$stable(mode_bits) |-> $past(cmd_valid))
    else $error("mode changed without command");
  scroll_on_a: assert property ($rose(scroll_active) |-> $past(cmd_valid) && $past(cmd_byte) == OP_SCROLL_GO)
    else $error("scroll started without go");
  scroll_off_a: assert property (!$past(rst) && $fell(scroll_active) |-> $past(cmd_byte) == OP_SCROLL_STOP)
    else $error("scroll stopped without stop");
  tick_gate_a: assert property (!scroll_active && !$past(scroll_active) |-> !scroll_tick)
    else $error("tick while stopped");
endmodule : dra_monitor

bind dra_core dra_monitor u_dra_monitor (.clock, .rst, .cmd_byte, .cmd_valid, .data_in,
  .mem_access, .col_ptr, .row_ptr, .data_mapped, .contrast_level, .current_range, .col_remap,
  .com_remap, .bit_remap, .vert_incr, .mono_mode, .scroll_active, .scroll_tick);

/* tb/dra_host_model.sv */
/*
  Host side model: drives the command and pixel byte stream.
  Assumes the bench calls its tasks from one sequence.
*/
module dra_host_model (
  input wire logic clock,
  output logic [7:0] cmd_byte,
  output logic cmd_valid,
  output logic [7:0] data_in,
  output logic mem_access
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    cmd_byte = 8'h00;
    cmd_valid = 1'b0;
    data_in = 8'h00;
    mem_access = 1'b0;
  end
  ////////////////////////////////////////
  // one byte; strobes drop after the taking edge, bus flips so no stale byte
  task automatic xfer(input logic c, input logic a, input logic [7:0] b);
    @(posedge clock);
    cmd_valid <= c;
    mem_access <= a;
    cmd_byte <= b;
    data_in <= b;
    @(posedge clock);
    cmd_valid <= 1'b0;
    mem_access <= 1'b0;
    cmd_byte <= ~b;
    data_in <= ~b;
    #1;
  endtask : xfer
  // window command; end is only ever programmed above start
  task automatic win(input logic [7:0] op, input logic [7:0] s, input logic [7:0] e);
    if (e > s) begin
      xfer(1'b1, 1'b0, op);
      xfer(1'b1, 1'b0, s);
      xfer(1'b1, 1'b0, e);
    end
  endtask : win
endmodule : dra_host_model

/* tb/tb_display_ram_addressing_remap.sv */
/*
  Self-checking bench for dra_core: windows, pointer walk, re-map, scroll.
  Assumes dra_host_model drives the byte stream; short scroll count.
*/
module tb_display_ram_addressing_remap
  import dra_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CYC = 8;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid, mem_access, col_remap, com_remap, bit_remap, vert_incr, mono_mode;
  logic scroll_active, scroll_dir_dec, scroll_tick;
  logic [7:0] cmd_byte, data_in, data_mapped, contrast_level, e;
  logic [6:0] col_ptr, seg_column, scroll_col_start, scroll_col_end;
  logic [4:0] row_ptr, com_row, scroll_row_start, scroll_row_end;
  logic [1:0] current_range, scroll_interval;
  logic [7:0] ops [3] = '{OP_RANGE_QTR, OP_RANGE_FULL, OP_RANGE_HALF};
  logic [1:0] rng [3] = '{RANGE_QTR, RANGE_FULL, RANGE_HALF};
  int err_count = 0;
  int n_compared = 0;
  int gap;
  `define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin err_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, x); end end
  ////////////////////////////////////////
  dra_core #(.SCROLL_CYC(CYC)) u_dra_core (.clock, .rst, .cmd_byte, .cmd_valid, .data_in,
    .mem_access, .col_ptr, .row_ptr, .data_mapped, .seg_column, .com_row, .contrast_level,
    .current_range, .col_remap, .com_remap, .bit_remap, .vert_incr, .mono_mode, .scroll_active,
    .scroll_dir_dec, .scroll_col_start, .scroll_col_end, .scroll_row_start, .scroll_row_end,
    .scroll_interval, .scroll_tick);
  dra_host_model u_dra_host_model (.clock, .cmd_byte, .cmd_valid, .data_in, .mem_access);
  initial forever #2.5 clock = ~clock;
  ////////////////////////////////////////
  task automatic cmd(input logic [7:0] b);
    u_dra_host_model.xfer(1'b1, 1'b0, b);
  endtask : cmd
  task automatic acc(input int n);
    repeat (n) u_dra_host_model.xfer(1'b0, 1'b1, 8'h5a);
  endtask : acc
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  // cycles between two ticks; bounded so a dead timer ends the run
  task automatic tick_gap(output int n);
    int k;
    k = 0;
    n = 0;
    while (k < 2 && n < 3000) begin
      @(posedge clock);
      #1;
      n++;
      if (scroll_tick === 1'b1) begin
        k++;
        if (k == 1) n = 0;
      end
    end
    if (n >= 3000) begin
      err_count++;
      tally_and_finish();
    end
  endtask : tick_gap
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    #1;
    `CHK(current_range, RANGE_HALF)
    `CHK({mono_mode, vert_incr, bit_remap, com_remap, col_remap}, REMAP_RESET)
    u_dra_host_model.win(OP_COL_WIN, 8'h02, 8'h7d);
    u_dra_host_model.win(OP_ROW_WIN, 8'h01, 8'h1f);
    `CHK(col_ptr, 7'h02)
    `CHK(row_ptr, 5'h01)
    acc(124);
    `CHK({col_ptr, row_ptr}, {7'h02, 5'h02})
    // last place of a small window wraps to its first
    u_dra_host_model.win(OP_ROW_WIN, 8'h1e, 8'h1f);
    u_dra_host_model.win(OP_COL_WIN, 8'h02, 8'h03);
    acc(4);
    `CHK({col_ptr, row_ptr}, {7'h02, 5'h1e})
    u_dra_host_model.xfer(1'b1, 1'b1, OP_RANGE_QTR);
    `CHK(col_ptr, 7'h02)
    foreach (ops[i]) begin
      cmd(ops[i]);
      `CHK(current_range, rng[i])
    end
    // a parameter byte that looks like an opcode is still a parameter
    cmd(OP_CONTRAST);
    cmd(8'hff);
    `CHK(contrast_level, 8'hff)
    cmd(OP_CONTRAST);
    cmd(OP_RANGE_QTR);
    `CHK({contrast_level, current_range}, {8'h84, RANGE_HALF})
    cmd(OP_REMAP);
    cmd(8'h08);
    acc(1);
    `CHK({col_ptr, row_ptr}, {7'h02, 5'h1f})
    acc(1);
    `CHK({col_ptr, row_ptr}, {7'h03, 5'h1e})
    cmd(OP_REMAP);
    cmd(8'h17);
    u_dra_host_model.xfer(1'b0, 1'b0, 8'h01);
    `CHK({mono_mode, data_mapped}, {1'b1, 8'h80})
    `CHK({seg_column, com_row}, {7'h1c, 5'h01})
    cmd(OP_REMAP);
    cmd(8'h05);
    u_dra_host_model.xfer(1'b0, 1'b0, 8'h12);
    `CHK(data_mapped, 8'h21)
    `CHK({seg_column, com_row}, {7'h7c, 5'h1e})
    // every interval code, direction alternating
    for (int i = 0; i < 4; i++) begin
      e = {3'h0, 1'(i), 2'h0, 2'(i)};
      cmd(OP_SCROLL_SETUP);
      cmd(8'h05);
      cmd(8'h01);
      cmd(8'h20);
      cmd(8'h1e);
      cmd(e);
      `CHK({scroll_col_start, scroll_row_start, scroll_col_end, scroll_row_end}, 24'h0a141e)
      `CHK({scroll_dir_dec, scroll_interval, scroll_active}, {e[4], e[1:0], 1'b0})
      cmd(OP_SCROLL_GO);
      `CHK(scroll_active, 1'b1)
      tick_gap(gap);
      `CHK(gap, CYC << i)
      cmd(OP_SCROLL_STOP);
      `CHK(scroll_active, 1'b0)
      acc(2); // image rewritten after stop
    end
    tally_and_finish();
  end
endmodule : tb_display_ram_addressing_remap
